// *** verilog/spi_regs_pkg.sv ***
// Register map, field layout and state types of the serial peripheral controller
package spi_regs_pkg;
	localparam int          ADDR_W           = 8;
	localparam logic [7:0]  OFS_CONTROL      = 8'h00;
	localparam logic [7:0]  OFS_MODE         = 8'h04;
	localparam logic [7:0]  OFS_RX           = 8'h08;
	localparam logic [7:0]  OFS_TX           = 8'h0C;
	localparam logic [7:0]  OFS_STATUS       = 8'h10;
	localparam logic [7:0]  OFS_IRQ_SET      = 8'h14;
	localparam logic [7:0]  OFS_IRQ_CLR      = 8'h18;
	localparam logic [7:0]  OFS_IRQ_MASK     = 8'h1C;
	// Control command bits
	localparam int          CTL_ENABLE       = 0;
	localparam int          CTL_DISABLE      = 1;
	// Mode register fields
	localparam int          MD_ROLE          = 0;
	localparam int          MD_VARSEL        = 1;
	localparam int          MD_DECODE        = 2;
	localparam int          MD_FDOFF         = 4;
	localparam int          MD_QUEUE         = 6;
	localparam int          MD_LOOP          = 7;
	localparam int          MD_PCS_LSB       = 16;
	localparam int          MD_GAP_LSB       = 24;
	localparam logic [31:0] MD_WRITABLE      = 32'hFF0F00D7;
	// Transmit word fields
	localparam int          TX_PCS_LSB       = 16;
	localparam int          TX_LAST          = 24;
	// Status bits
	localparam int          ST_RXFULL        = 0;
	localparam int          ST_SHIFTER_IDLE_FLAG       = 1;
	localparam int          ST_FAULT         = 2;
	localparam int          ST_OVERRUN       = 3;
	localparam int          ST_SELRISE       = 8;
	localparam int          ST_IDLE          = 9;
	localparam int          ST_UNDERRUN      = 10;
	localparam int          ST_ENABLED       = 16;
	localparam logic [10:0] IRQ_BITS         = 11'h70F;
	localparam logic [7:0]  MIN_GAP          = 8'h06;
	localparam logic [3:0]  PCS_NONE         = 4'hF;
	localparam int          RX_DEPTH         = 4;

	typedef enum logic [1:0] {PH_IDLE, PH_GAP, PH_SHIFT} phase_t;

	typedef struct packed {
		logic              en;
		logic              dis_pend;
		logic [31:0]       mode;
		logic [15:0]       tx_data;
		logic [3:0]        tx_pcs;
		logic              tx_last;
		logic              tx_full;
		phase_t            phase;
		logic [15:0]       shreg;
		logic [4:0]        bitcnt;
		logic [7:0]        divcnt;
		logic [7:0]        gapcnt;
		logic [3:0]        cur_pcs;
		logic              cur_last;
		logic              cs_active;
		logic              slv_act;
		logic [3:0][15:0]  rx_mem;
		logic [2:0]        rx_cnt;
		logic [1:0]        rd_ptr;
		logic              transmit_empty_flag;
		logic              underrun_flag;
		logic              selrise;
		logic              overrun_flag;
		logic              fault;
		logic [10:0]       mask;
		logic [2:0]        spck_s;
		logic [2:0]        nss_s;
		logic [1:0]        miso_s;
		logic [1:0]        mosi_s;
		logic [3:0]        cs_n;
		logic              pins_master;
		logic              spck_o;
		logic              mosi_o;
		logic              miso_o;
		logic              miso_drive;
		logic [1:0]        cfg_idx;
		logic [31:0]       rdata;
	} state_t;
endpackage : spi_regs_pkg

// *** verilog/spi_ctrl.sv ***
// Serial peripheral controller: registers, select logic, shifter and receive queue
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

// How it works
// - disable finishes transfer, then releases pins
// - enable plus disable together means disable
// - enable command allows transfers; zeros ignored
// - select gap is delay field, minimum six
// - without decode, lowest zero selects line
// - with decode, select lines equal code
// - decoded selects grouped four per configuration
// - master loopback routes output to input
// - receive queue holds four, else one
// - fault-detect-off bit disables mode faults
// - fixed or per-word select code
// - role bit chooses master or slave
// - received data right-justified, upper zero
// - final character flag releases select
// - status bit 16 shows enabled
// - status read clears error flags
// - transmit-empty zero when disabled, enable sets
// - mask set and clear by one bits
module spi_ctrl #(
	parameter int DATA_BITS = 8,
	parameter int HALF_DIV  = 4
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        spck_i,
	output logic             spck_o,
	output logic             spck_oe_n,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe_n,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe_n,
	input  wire logic        nss_i,
	output logic      [3:0]  chip_select_lines_n,
	output logic      [3:0]  chip_select_oe_n,
	output logic      [1:0]  select_config_idx
);
	spi_regs_pkg::state_t q;
	spi_regs_pkg::state_t d;

	// Line pattern for a select code
	function automatic logic [3:0] select_lines(input logic [3:0] code, input logic dec);
		logic [3:0] r;
		r = 4'hF;
		if (dec)
			r = code;
		else if (!code[0])
			r = 4'hE;
		else if (!code[1])
			r = 4'hD;
		else if (!code[2])
			r = 4'hB;
		else if (!code[3])
			r = 4'h7;
		return r;
	endfunction : select_lines

	// Which select configuration a code uses
	function automatic logic [1:0] config_index(input logic [3:0] code, input logic dec);
		logic [1:0] r;
		r = 2'h0;
		if (dec)
			r = code[3:2];
		else if (!code[0])
			r = 2'h0;
		else if (!code[1])
			r = 2'h1;
		else if (!code[2])
			r = 2'h2;
		else
			r = 2'h3;
		return r;
	endfunction : config_index

	// Store one character into the receive queue
	function automatic spi_regs_pkg::state_t rx_push(input spi_regs_pkg::state_t s, input logic [15:0] v);
		spi_regs_pkg::state_t r;
		logic [2:0] depth;
		logic [1:0] wp;
		r = s;
		depth = s.mode[spi_regs_pkg::MD_QUEUE] ? 3'(spi_regs_pkg::RX_DEPTH) : 3'h1;
		wp = 2'(s.rd_ptr + s.rx_cnt[1:0]);
		if (s.rx_cnt >= depth) begin
			r.overrun_flag = 1'b1;
			// Single-entry mode keeps the newest character
			if (!s.mode[spi_regs_pkg::MD_QUEUE])
				r.rx_mem[s.rd_ptr] = v;
		end else begin
			r.rx_mem[wp] = v;
			r.rx_cnt = 3'(s.rx_cnt + 3'h1);
		end
		return r;
	endfunction : rx_push

	logic [15:0] data_mask;
	assign data_mask = 16'((32'h1 << DATA_BITS) - 1);

	always_comb begin
		logic [3:0]  code;
		logic [7:0]  gap_len;
		logic        master;
		logic        spck_rise;
		logic        spck_fall;
		logic        nss_fall;
		logic        nss_rise;
		logic        in_bit;
		logic [31:0] status;
		d = q;
		code = q.mode[spi_regs_pkg::MD_VARSEL] ? q.tx_pcs : q.mode[spi_regs_pkg::MD_PCS_LSB +: 4];
		gap_len = (q.mode[spi_regs_pkg::MD_GAP_LSB +: 8] <= spi_regs_pkg::MIN_GAP) ?
			spi_regs_pkg::MIN_GAP : q.mode[spi_regs_pkg::MD_GAP_LSB +: 8];
		master = q.en && q.mode[spi_regs_pkg::MD_ROLE];
		spck_rise = q.spck_s[1] && !q.spck_s[2];
		spck_fall = !q.spck_s[1] && q.spck_s[2];
		nss_fall = !q.nss_s[1] && q.nss_s[2];
		nss_rise = q.nss_s[1] && !q.nss_s[2];
		in_bit = q.mode[spi_regs_pkg::MD_LOOP] ? q.mosi_o : q.miso_s[1];
		status = 32'h0;
		status[spi_regs_pkg::ST_RXFULL] = q.rx_cnt != 3'h0;
		status[spi_regs_pkg::ST_SHIFTER_IDLE_FLAG] = q.transmit_empty_flag;
		status[spi_regs_pkg::ST_FAULT] = q.fault;
		status[spi_regs_pkg::ST_OVERRUN] = q.overrun_flag;
		status[spi_regs_pkg::ST_SELRISE] = q.selrise;
		status[spi_regs_pkg::ST_IDLE] = q.en && !q.tx_full && q.phase == spi_regs_pkg::PH_IDLE && !q.slv_act;
		status[spi_regs_pkg::ST_UNDERRUN] = q.underrun_flag;
		status[spi_regs_pkg::ST_ENABLED] = q.en;

		// Input synchronisers; only stage two and beyond are read by logic
		d.spck_s = {q.spck_s[1:0], spck_i};
		d.nss_s = {q.nss_s[1:0], nss_i};
		d.miso_s = {q.miso_s[0], miso_i};
		d.mosi_s = {q.mosi_s[0], mosi_i};

		// Register reads; unmapped and reserved bits read zero
		d.rdata = 32'h0;
		if (rd) begin
			case (addr)
				spi_regs_pkg::OFS_MODE: d.rdata = q.mode;
				spi_regs_pkg::OFS_RX: begin
					d.rdata = {16'h0, q.rx_mem[q.rd_ptr] & data_mask};
					if (q.rx_cnt != 3'h0) begin
						d.rd_ptr = 2'(q.rd_ptr + 2'h1);
						d.rx_cnt = 3'(q.rx_cnt - 3'h1);
					end
				end
				spi_regs_pkg::OFS_STATUS: begin
					d.rdata = status;
					d.underrun_flag = 1'b0;
					d.selrise = 1'b0;
					d.overrun_flag = 1'b0;
					d.fault = 1'b0;
				end
				spi_regs_pkg::OFS_IRQ_MASK: d.rdata = {21'h0, q.mask};
				default: d.rdata = 32'h0;
			endcase
		end

		// Register writes
		if (wr) begin
			case (addr)
				spi_regs_pkg::OFS_CONTROL: begin
					if (wdata[spi_regs_pkg::CTL_DISABLE])
						d.dis_pend = 1'b1;
					else if (wdata[spi_regs_pkg::CTL_ENABLE] && !q.en) begin
						d.en = 1'b1;
						d.transmit_empty_flag = 1'b1;
					end
				end
				spi_regs_pkg::OFS_MODE: d.mode = wdata & spi_regs_pkg::MD_WRITABLE;
				spi_regs_pkg::OFS_TX: begin
					d.tx_data = wdata[15:0] & data_mask;
					d.tx_pcs = wdata[spi_regs_pkg::TX_PCS_LSB +: 4];
					d.tx_last = wdata[spi_regs_pkg::TX_LAST];
					d.tx_full = 1'b1;
					d.transmit_empty_flag = 1'b0;
				end
				spi_regs_pkg::OFS_IRQ_SET: d.mask = q.mask | (wdata[10:0] & spi_regs_pkg::IRQ_BITS);
				spi_regs_pkg::OFS_IRQ_CLR: d.mask = q.mask & ~wdata[10:0];
				default: ;
			endcase
		end

		// Master engine
		case (q.phase)
			spi_regs_pkg::PH_IDLE: begin
				if (master && q.tx_full && !q.dis_pend) begin
					if (q.cs_active && code == q.cur_pcs) begin
						d.phase = spi_regs_pkg::PH_GAP;
						d.gapcnt = 8'h0;
					end else begin
						// Release the old select before counting the gap
						d.cs_n = 4'hF;
						d.cs_active = 1'b0;
						d.phase = spi_regs_pkg::PH_GAP;
						d.gapcnt = gap_len;
					end
				end
			end
			spi_regs_pkg::PH_GAP: begin
				if (q.gapcnt > 8'h1) begin
					d.gapcnt = 8'(q.gapcnt - 8'h1);
				end else begin
					d.cur_pcs = code;
					d.cs_n = select_lines(code, q.mode[spi_regs_pkg::MD_DECODE]);
					d.cfg_idx = config_index(code, q.mode[spi_regs_pkg::MD_DECODE]);
					d.cs_active = 1'b1;
					d.cur_last = q.tx_last;
					d.shreg = q.tx_data;
					d.mosi_o = q.tx_data[DATA_BITS-1];
					d.tx_full = 1'b0;
					d.transmit_empty_flag = 1'b1;
					d.bitcnt = 5'(DATA_BITS);
					d.divcnt = 8'(HALF_DIV);
					d.spck_o = 1'b0;
					d.phase = spi_regs_pkg::PH_SHIFT;
				end
			end
			spi_regs_pkg::PH_SHIFT: begin
				if (q.divcnt > 8'h1) begin
					d.divcnt = 8'(q.divcnt - 8'h1);
				end else begin
					d.divcnt = 8'(HALF_DIV);
					d.spck_o = !q.spck_o;
					if (!q.spck_o) begin
						d.shreg = {q.shreg[14:0], in_bit};
					end else if (q.bitcnt > 5'h1) begin
						d.bitcnt = 5'(q.bitcnt - 5'h1);
						d.mosi_o = q.shreg[DATA_BITS-1];
					end else begin
						d = rx_push(d, q.shreg & data_mask);
						d.phase = spi_regs_pkg::PH_IDLE;
						// Without further data the select is released
						if (q.cur_last || !d.tx_full) begin
							d.cs_n = 4'hF;
							d.cs_active = 1'b0;
						end
					end
				end
			end
			default: d.phase = spi_regs_pkg::PH_IDLE;
		endcase

		// Slave engine, stepped by synchronised edges of the external serial clock
		if (q.en && !q.mode[spi_regs_pkg::MD_ROLE]) begin
			if (nss_rise)
				d.selrise = 1'b1;
			if (nss_fall) begin
				d.slv_act = 1'b1;
				d.bitcnt = 5'(DATA_BITS);
				if (d.tx_full) begin
					d.shreg = d.tx_data;
					d.tx_full = 1'b0;
					d.transmit_empty_flag = 1'b1;
				end else begin
					d.underrun_flag = 1'b1;
				end
				d.miso_o = d.shreg[DATA_BITS-1];
			end else if (q.slv_act && q.nss_s[1]) begin
				d.slv_act = 1'b0;
			end else if (q.slv_act && spck_rise) begin
				d.shreg = {q.shreg[14:0], q.mosi_s[1]};
				if (q.bitcnt > 5'h1) begin
					d.bitcnt = 5'(q.bitcnt - 5'h1);
				end else begin
					d = rx_push(d, {q.shreg[14:0], q.mosi_s[1]} & data_mask);
					d.bitcnt = 5'(DATA_BITS);
				end
			end else if (q.slv_act && spck_fall) begin
				d.miso_o = q.shreg[DATA_BITS-1];
			end
		end
		d.miso_drive = q.en && !q.mode[spi_regs_pkg::MD_ROLE] && !q.nss_s[1];

		// Mode fault: another master pulls select line zero low
		if (master && !q.mode[spi_regs_pkg::MD_FDOFF] && q.cs_n[0] && !q.nss_s[1]) begin
			d.fault = 1'b1;
			d.en = 1'b0;
			d.transmit_empty_flag = 1'b0;
			d.phase = spi_regs_pkg::PH_IDLE;
			d.cs_n = 4'hF;
			d.cs_active = 1'b0;
		end

		// Disable waits for the character on the wire to finish
		if (d.dis_pend && d.phase == spi_regs_pkg::PH_IDLE && !d.slv_act) begin
			d.en = 1'b0;
			d.dis_pend = 1'b0;
			d.transmit_empty_flag = 1'b0;
			d.cs_n = 4'hF;
			d.cs_active = 1'b0;
		end
		d.pins_master = d.en && d.mode[spi_regs_pkg::MD_ROLE];
		if (!d.pins_master)
			d.spck_o = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
			q.phase <= spi_regs_pkg::PH_IDLE;
			q.cs_n <= 4'hF;
			q.spck_s <= 3'h0;
			q.nss_s <= 3'h7;
		end else begin
			q <= d;
		end
	end

	// Disabled: every pin is released to input
	assign rdata = q.rdata;
	assign spck_o = q.spck_o;
	assign spck_oe_n = !q.pins_master;
	assign mosi_o = q.mosi_o;
	assign mosi_oe_n = !q.pins_master;
	assign miso_o = q.miso_o;
	assign miso_oe_n = !q.miso_drive;
	assign chip_select_lines_n = q.cs_n;
	assign chip_select_oe_n = {4{!q.pins_master}};
	assign select_config_idx = q.cfg_idx;
endmodule : spi_ctrl

// *** verification/spi_ctrl_monitor.sv ***
// Bound port checker of the serial peripheral controller
`timescale 1ns/1ps
module spi_ctrl_monitor #(
	parameter int DATA_BITS = 8
) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        spck_oe_n,
	input wire logic        mosi_oe_n,
	input wire logic [3:0]  chip_select_lines_n,
	input wire logic [3:0]  chip_select_oe_n,
	input wire logic [1:0]  select_config_idx
);
	logic [31:0] mode_q;
	logic [3:0]  tx_q;
	logic [8:0]  idle_q;
	logic [7:0]  gap_min;
	logic        sel;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	assign sel = chip_select_lines_n != 4'hF;
	assign gap_min = (mode_q[31:24] > 8'h06) ? mode_q[31:24] : 8'h06;
	// Shadows rebuilt from bus writes; the checker sees no internal state
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_q <= 32'h0;
			tx_q <= 4'h0;
			idle_q <= 9'h0;
		end else begin
			if (wr && addr == 8'h04) mode_q <= wdata;
			if (wr && addr == 8'h0C) tx_q <= wdata[19:16];
			idle_q <= sel ? 9'h0 : idle_q + {8'h0, idle_q != 9'h1FF};
		end
	end
	sequence s_enable;
		wr && addr == 8'h00 && wdata[1:0] == 2'b01;
	endsequence
	sequence s_stat;
		rd && addr == 8'h10;
	endsequence
	a_gap_min_wait: assert property (sel && !$past(sel) |-> idle_q >= {1'b0, gap_min})
		else $error("select gap too short");
	a_plain_select_hot: assert property (!mode_q[2] && sel |-> chip_select_lines_n inside {4'hE, 4'hD, 4'hB, 4'h7})
		else $error("plain select not a single line");
	a_decode_direct: assert property (mode_q[2] && sel |-> chip_select_lines_n == (mode_q[1] ? tx_q : mode_q[19:16]))
		else $error("decoded select differs from code");
	a_config_group: assert property (mode_q[2] && sel && $stable(chip_select_lines_n) |-> select_config_idx == chip_select_lines_n[3:2])
		else $error("wrong select configuration");
	a_disable_release: assert property (wr && addr == 8'h00 && wdata[1] |-> ##[1:1000] (spck_oe_n && mosi_oe_n && chip_select_oe_n == 4'hF))
		else $error("pins not released after disable");
	a_enable_status: assert property (s_enable ##2 s_stat |=> rdata[16] && rdata[1])
		else $error("enable not reported");
	a_rx_justified: assert property (rd && addr == 8'h08 |=> rdata[31:DATA_BITS] == '0)
		else $error("receive upper bits not zero");
	a_reserved_zero: assert property (rd && addr == 8'h04 |=> (rdata & ~spi_regs_pkg::MD_WRITABLE) == 32'h0)
		else $error("reserved mode bits not zero");
	a_status_clear: assert property (s_stat ##2 s_stat |=> rdata[10] == 1'b0 && rdata[8] == 1'b0 && rdata[3:2] == 2'b00)
		else $error("status flags not cleared by read");
endmodule : spi_ctrl_monitor

bind spi_ctrl spi_ctrl_monitor #(.DATA_BITS(DATA_BITS)) u_mon (
	.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .spck_oe_n, .mosi_oe_n,
	.chip_select_lines_n, .chip_select_oe_n, .select_config_idx
);

// *** verification/spi_peer_model.sv ***
// Behavioural serial peripheral on the select lines
`timescale 1ns/1ps
module spi_peer_model #(
	parameter logic [7:0] REPLY = 8'hA5
) (
	input  wire logic       clk,
	input  wire logic       sck,
	input  wire logic       sdi,
	input  wire logic [3:0] cs_n,
	output logic            sdo,
	output logic [7:0]      got
);
	logic [7:0] sh = 8'hA5;
	logic       sck_q = 1'b0;
	logic       idle_t = 1'b0;
	wire        sel = cs_n != 4'hF;
	// Unselected line toggles so a stale bit never looks valid
	assign sdo = sel ? sh[7] : idle_t;
	always @(posedge clk) begin
		sck_q <= sck;
		idle_t <= ~idle_t;
		if (!sel) sh <= REPLY;
		else if (sck_q && !sck) sh <= {sh[6:0], 1'b0};
		if (sel && !sck_q && sck) got <= {got[6:0], sdi};
	end
endmodule : spi_peer_model

// *** verification/spi_mode_data_status_regs_tb.sv ***
// Self-checking bench of the serial peripheral controller
`timescale 1ns/1ps
module spi_mode_data_status_regs_tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        spck_tb = 1'b0;
	logic        mosi_tb = 1'b0;
	logic        nss_i = 1'b1;
	logic [31:0] rdata, v;
	logic        spck_o, spck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, peer_sdo;
	logic [3:0]  cs_n, cs_oe_n, cs_seen;
	logic [1:0]  idx, idx_seen;
	logic [7:0]  got, back;
	logic [7:0]  regs [5] = '{8'h04, 8'h08, 8'h10, 8'h1C, 8'h40};
	logic [3:0]  codes [4] = '{4'h6, 4'h5, 4'hB, 4'h7};
	logic [3:0]  lines [4] = '{4'hE, 4'hD, 4'hB, 4'h7};
	wire         sck_w = spck_oe_n ? spck_tb : spck_o;
	wire         mosi_w = mosi_oe_n ? mosi_tb : mosi_o;
	wire         miso_w = miso_oe_n ? peer_sdo : miso_o;
	wire  [3:0]  cs_w = (cs_oe_n == 4'h0) ? cs_n : 4'hF;
	int          errors = 0;
	int          compares = 0;
	always #20 clk = ~clk;
	spi_ctrl #(.DATA_BITS(8), .HALF_DIV(4)) u_dut (
		.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
		.spck_i(sck_w), .spck_o, .spck_oe_n, .mosi_i(mosi_w), .mosi_o, .mosi_oe_n,
		.miso_i(miso_w), .miso_o, .miso_oe_n, .nss_i,
		.chip_select_lines_n(cs_n), .chip_select_oe_n(cs_oe_n), .select_config_idx(idx)
	);
	spi_peer_model u_peer (.clk, .sck(sck_w), .sdi(mosi_w), .cs_n(cs_w), .sdo(peer_sdo), .got);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wreg
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask : rreg
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rreg(a, v);
		chk(nm, e, v & m);
	endtask : rchk
	task automatic xfer(input logic [31:0] w, input logic dis);
		int n;
		n = 0;
		wreg(8'h0C, w);
		while (cs_w == 4'hF && n < 500) begin
			@(posedge clk);
			n++;
		end
		chk("select_seen", 32'h1, {31'h0, cs_w != 4'hF});
		cs_seen = cs_w;
		idx_seen = idx;
		if (dis) wreg(8'h00, 32'h2);
		while (cs_w != 4'hF && n < 1000) begin
			@(posedge clk);
			n++;
		end
		chk("select_freed", 32'h1, {31'h0, cs_w == 4'hF});
		repeat (2) @(posedge clk);
	endtask : xfer
	// Second word queued while the first shifts; counts select releases over both
	task automatic hold_check(input logic [31:0] w, input logic [31:0] e);
		int n;
		int rel;
		logic act;
		n = 0;
		rel = 0;
		wreg(8'h0C, w);
		while (cs_w == 4'hF && n < 100) begin
			@(posedge clk);
			n++;
		end
		wreg(8'h0C, {w[31:25], 1'b0, w[23:0]});
		act = 1'b1;
		repeat (200) begin
			@(posedge clk);
			if (act && cs_w == 4'hF)
				rel++;
			act = cs_w != 4'hF;
		end
		chk("releases", e, 32'(rel));
	endtask : hold_check
	// Link clock of 320 ns; the reply bit is taken as the link clock rises
	task automatic slave_frame(input logic [7:0] b, output logic [7:0] s);
		nss_i <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 7; i >= 0; i--) begin
			mosi_tb <= b[i];
			repeat (4) @(posedge clk);
			spck_tb <= 1'b1;
			s[i] = miso_w;
			repeat (4) @(posedge clk);
			spck_tb <= 1'b0;
		end
		repeat (8) @(posedge clk);
		nss_i <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : slave_frame
	task automatic final_report;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		foreach (regs[i]) rchk("reset", regs[i], 32'hFFFFFFFF, 32'h0);
		wreg(8'h40, 32'hFFFFFFFF);
		rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
		wreg(8'h04, 32'hFFFFFFFF);
		rchk("mode", 8'h04, 32'hFFFFFFFF, spi_regs_pkg::MD_WRITABLE);
		wreg(8'h14, 32'hFFFFFFFF);
		wreg(8'h18, 32'h00000103);
		wreg(8'h14, 32'h0);
		rchk("mask", 8'h1C, 32'hFFFFFFFF, 32'h0000060C);
		wreg(8'h04, 32'h02030001);
		wreg(8'h00, 32'h3);
		rchk("both", 8'h10, 32'h00010002, 32'h0);
		wreg(8'h00, 32'h1);
		rchk("enable", 8'h10, 32'h00010002, 32'h00010002);
		wreg(8'h00, 32'h0);
		rchk("zero", 8'h10, 32'h00010002, 32'h00010002);
		xfer(32'h000E003C, 1'b0);
		chk("fixed", 32'hB, {28'h0, cs_seen});
		chk("mosi", 32'h3C, {24'h0, got});
		rchk("rx", 8'h08, 32'hFFFFFFFF, 32'hA5);
		wreg(8'h04, 32'h02030081);
		xfer(32'h5A, 1'b0);
		rchk("loop", 8'h08, 32'hFFFFFFFF, 32'h5A);
		wreg(8'h04, 32'h00000003);
		for (int i = 0; i < 4; i++) begin
			xfer({12'h0, codes[i], 16'h0011}, 1'b0);
			chk("plain", {28'h0, lines[i]}, {28'h0, cs_seen});
			rreg(8'h08, v);
		end
		wreg(8'h04, 32'h00000007);
		xfer(32'h01090066, 1'b0);
		chk("decode", 32'h9, {28'h0, cs_seen});
		chk("group", 32'h2, {30'h0, idx_seen});
		hold_check(32'h01090066, 32'h2);
		hold_check(32'h00090066, 32'h1);
		rreg(8'h10, v);
		rreg(8'h08, v);
		wreg(8'h04, 32'h00030041);
		for (int i = 0; i < 5; i++) begin
			xfer(32'h11, 1'b0);
			rchk("queue", 8'h10, 32'h8, (i == 4) ? 32'h8 : 32'h0);
		end
		rchk("cleared", 8'h10, 32'h8, 32'h0);
		repeat (4) rchk("queued", 8'h08, 32'hFFFFFFFF, 32'hA5);
		rchk("drained", 8'h10, 32'h1, 32'h0);
		wreg(8'h04, 32'h00030001);
		xfer(32'h11, 1'b0);
		xfer(32'h11, 1'b0);
		rchk("single", 8'h10, 32'h9, 32'h9);
		rreg(8'h08, v);
		wreg(8'h04, 32'h00030011);
		nss_i <= 1'b0;
		repeat (8) @(posedge clk);
		rchk("nofault", 8'h10, 32'h00010004, 32'h00010000);
		wreg(8'h04, 32'h00030001);
		repeat (8) @(posedge clk);
		rchk("fault", 8'h10, 32'h00010004, 32'h00000004);
		nss_i <= 1'b1;
		// Let the select input clear its synchroniser before re-enabling
		repeat (4) @(posedge clk);
		wreg(8'h00, 32'h1);
		xfer(32'h000000C9, 1'b1);
		chk("finish", 32'hC9, {24'h0, got});
		chk("pins", 32'h3F, {26'h0, spck_oe_n, mosi_oe_n, cs_oe_n});
		rchk("off", 8'h10, 32'h00010002, 32'h0);
		rreg(8'h08, v);
		wreg(8'h04, 32'h0);
		wreg(8'h00, 32'h1);
		slave_frame(8'hC3, back);
		rchk("sflags", 8'h10, 32'h00000501, 32'h00000501);
		rchk("sclear", 8'h10, 32'h00000500, 32'h0);
		rchk("srx", 8'h08, 32'hFFFFFFFF, 32'hC3);
		wreg(8'h0C, 32'h0000005A);
		slave_frame(8'h96, back);
		chk("miso", 32'h5A, {24'h0, back});
		rchk("sload", 8'h10, 32'h00000401, 32'h00000001);
		rchk("srx2", 8'h08, 32'hFFFFFFFF, 32'h96);
		final_report;
	end
	initial begin
		repeat (6000) @(posedge clk);
		errors++;
		final_report;
	end
endmodule : spi_mode_data_status_regs_tb
